// ### config_integrity_monitor.sv
// configuration integrity monitor: checks, map crc and clock counter
//
// Operation
// (R1) transfer checksum is checked only while its enable bit is one
// (R2) enable bit 1 runs periodic map crc; mismatch sets map crc flag
// (R3) map crc skips read-only locations: status, data, clock counter
// (R4) map crc recomputed and compared every 426.6 us while enabled
// (R5) legitimate map writes recompute the stored reference crc
// (R6) refresh on host write, calibration, single-to-idle, read exit
// (R7) rom check always started at power-up regardless of enables
// (R8) enable bit 0 gates rom failure reporting; resets to zero
// (R9) clock counter at 0x08 resets to zero, reads live count
// (R10) counter steps every 131 master pulses and wraps at maximum
// (R11) host sets counter enable before trusting the count
// (R12) failed write checksum sets flag; host reads back to confirm
// (R13) map crc flag stays set until software clears it
`timescale 1ns/1ps
`default_nettype none
`include "cim_map.svh"

module config_integrity_monitor
#(
    parameter int unsigned CHK_CYCLES = `CHK_PERIOD_NS / `CLK_PERIOD_NS
)
(
    // clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst,
    // register port
    input  wire logic               i_wr_en,
    input  wire logic               i_wr_chk_ok,
    input  wire logic               i_rd_en,
    input  wire logic [7:0]         i_addr,
    input  wire logic [23:0]        i_wdata,
    output logic                    o_wr_commit,
    output logic                    o_rd_valid,
    output logic      [23:0]        o_rdata,
    // map scan port
    output logic      [7:0]         o_scan_addr,
    input  wire logic [23:0]        i_scan_data,
    // adc activity
    input  wire logic               i_cal_done,
    input  wire logic               i_mode_single,
    input  wire logic               i_mode_idle,
    input  wire logic               i_continuous_read_bit,
    // rom check
    output logic                    o_rom_check_start,
    input  wire logic               i_rom_done,
    input  wire logic               i_rom_fail,
    // error register flags
    input  wire cim_pkg::err_flags_t i_err_clr,
    output cim_pkg::err_flags_t     o_err_flags,
    output logic                    o_xfer_chk_active
);

    localparam logic [12:0] CHK_LAST = 13'(CHK_CYCLES - 1);

    logic [23:0]           err_en_r;
    cim_pkg::err_flags_t   err_r;
    cim_pkg::scan_state_t  state_r;
    cim_pkg::refresh_ev_t  ev;
    logic [7:0]            scan_addr_r;
    logic                  ref_mode_r;
    logic [7:0]            ref_crc_r;
    logic [7:0]            crc;
    logic                  refresh_pend_r;
    logic                  chk_pend_r;
    logic [12:0]           timer_r;
    logic                  chk_tick;
    logic                  cmp_fail;
    logic                  take;
    logic                  mode_single_r;
    logic                  continuous_read_bit_r;
    logic                  rom_started_r;
    logic                  rom_fail_r;
    logic                  xfer_bad;
    logic                  any_ev;
    logic [7:0]            clk_count;

    // ****************************************************************
    // register port
    // ****************************************************************

    // read-only locations never take part in the map checksum
    function automatic logic is_ro(input logic [7:0] a);
        return (a == `ADDR_STATUS) || (a == `ADDR_DATA) ||
               (a == `ADDR_CLK_CNT);
    endfunction

    assign o_xfer_chk_active = err_en_r[`EN_XFER_BIT];
    // a bad checksum only matters while checking is switched on
    assign xfer_bad    = i_wr_en && o_xfer_chk_active
                         && !i_wr_chk_ok; // (R1)
    assign o_wr_commit = i_wr_en && !xfer_bad; // (R1)

    // error-enable register, written only by committed writes
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            err_en_r <= `ERR_EN_RESET; // (R8)
        else if (o_wr_commit && i_addr == `ADDR_ERR_EN)
            err_en_r <= i_wdata;
    end

    // read data registered, one cycle after the request
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata    <= 24'h000000;
            o_rd_valid <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_rd_en;
            if (!i_rd_en)
                o_rdata <= o_rdata;
            else if (i_addr == `ADDR_CLK_CNT)
                o_rdata <= {16'h0000, clk_count}; // (R9)
            else if (i_addr == `ADDR_ERR_EN)
                o_rdata <= err_en_r;
            else
                o_rdata <= 24'h000000;
        end
    end

    // ****************************************************************
    // refresh causes
    // ****************************************************************

    // previous levels for fall detection
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_single_r <= 1'b0;
            continuous_read_bit_r   <= 1'b0;
        end
        else
        begin
            mode_single_r <= i_mode_single;
            continuous_read_bit_r   <= i_continuous_read_bit;
        end
    end

    // every legitimate change of map contents refreshes the reference
    always_comb
    begin
        ev.host_wr   = o_wr_commit; // (R5)
        ev.cal       = i_cal_done; // (R6)
        ev.mode_idle = mode_single_r && i_mode_idle; // (R6)
        ev.cont_off  = continuous_read_bit_r && !i_continuous_read_bit; // (R6)
    end
    assign any_ev = |ev;

    // pending refresh; reset sets it so a reference exists at start
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            refresh_pend_r <= 1'b1;
        else if (any_ev)
            refresh_pend_r <= 1'b1; // (R5)
        else if (state_r == cim_pkg::S_IDLE)
            refresh_pend_r <= 1'b0;
    end

    // ****************************************************************
    // periodic check timer
    // ****************************************************************

    // free period counter, stopped while the check is off
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            timer_r <= 13'h0000;
        else if (!err_en_r[`EN_MAP_BIT] || chk_tick)
            timer_r <= 13'h0000;
        else
            timer_r <= timer_r + 13'h0001;
    end
    assign chk_tick = err_en_r[`EN_MAP_BIT]
                      && (timer_r == CHK_LAST); // (R4)

    // a tick waits while a refresh scan is busy
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            chk_pend_r <= 1'b0;
        else if (chk_tick)
            chk_pend_r <= 1'b1; // (R4)
        else if (state_r == cim_pkg::S_IDLE && !refresh_pend_r)
            chk_pend_r <= 1'b0;
    end

    // ****************************************************************
    // scan sequencer
    // ****************************************************************

    // a map change during a compare scan aborts it, since the
    // old reference no longer describes the map
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r     <= cim_pkg::S_IDLE;
            scan_addr_r <= `MAP_FIRST;
            ref_mode_r  <= 1'b0;
        end
        else
        begin
            case (state_r)
                cim_pkg::S_IDLE:
                begin
                    scan_addr_r <= `MAP_FIRST;
                    if (refresh_pend_r || any_ev)
                    begin
                        ref_mode_r <= 1'b1; // (R5)
                        state_r    <= cim_pkg::S_SCAN;
                    end
                    else if (chk_pend_r && err_en_r[`EN_MAP_BIT])
                    begin
                        ref_mode_r <= 1'b0;
                        state_r    <= cim_pkg::S_SCAN;
                    end
                end
                cim_pkg::S_SCAN:
                begin
                    if (any_ev)
                        state_r <= cim_pkg::S_IDLE;
                    else if (scan_addr_r == `MAP_LAST)
                        state_r <= cim_pkg::S_DONE;
                    else
                        scan_addr_r <= scan_addr_r + 8'h01;
                end
                cim_pkg::S_DONE:
                    state_r <= cim_pkg::S_IDLE;
                default:
                    state_r <= cim_pkg::S_IDLE;
            endcase
        end
    end

    assign o_scan_addr = scan_addr_r;
    assign take = (state_r == cim_pkg::S_SCAN) && !any_ev
                  && !is_ro(scan_addr_r); // (R3)

    map_crc_engine u_crc
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_clear   (state_r == cim_pkg::S_IDLE),
        .i_take    (take),
        .i_word    (i_scan_data),
        .o_crc     (crc)
    );

    // reference store at the end of a refresh scan
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            ref_crc_r <= `CRC_SEED;
        else if (state_r == cim_pkg::S_DONE && ref_mode_r)
            ref_crc_r <= crc; // (R5)
    end

    assign cmp_fail = (state_r == cim_pkg::S_DONE) && !ref_mode_r
                      && (crc != ref_crc_r) && !any_ev; // (R2)

    // ****************************************************************
    // rom check at power-up
    // ****************************************************************

    // start pulse in the first cycle after reset, independent of enables
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rom_started_r <= 1'b0;
        else
            rom_started_r <= 1'b1;
    end
    assign o_rom_check_start = !rom_started_r; // (R7)

    // failure kept whether or not it is reported
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rom_fail_r <= 1'b0;
        else if (i_rom_done && i_rom_fail)
            rom_fail_r <= 1'b1; // (R7)
    end

    // ****************************************************************
    // error flags; a set in the clearing cycle wins
    // ****************************************************************

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            err_r <= '0;
        else
        begin
            if (cmp_fail && err_en_r[`EN_MAP_BIT])
                err_r.map_crc <= 1'b1; // (R2)
            else if (i_err_clr.map_crc)
                err_r.map_crc <= 1'b0; // (R13)
            if (rom_fail_r && err_en_r[`EN_ROM_BIT])
                err_r.rom <= 1'b1; // (R8)
            else if (i_err_clr.rom)
                err_r.rom <= 1'b0;
            if (xfer_bad)
                err_r.xfer_chk <= 1'b1; // (R12)
            else if (i_err_clr.xfer_chk)
                err_r.xfer_chk <= 1'b0;
        end
    end
    assign o_err_flags = err_r;

    // ****************************************************************
    // clock counter
    // ****************************************************************

    // host must enable before reading a meaningful count
    clock_tick_counter u_cnt
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_enable  (err_en_r[`EN_CNT_BIT]), // (R11)
        .o_count   (clk_count)
    );

    // ****************************************************************
    // assertions
    // ****************************************************************

    property p_xfer_block;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_wr_en && o_xfer_chk_active && !i_wr_chk_ok |-> !o_wr_commit;
    endproperty
    a_xfer_block: assert property (p_xfer_block) // (R1)
        else $error("bad checksum write committed");

    property p_xfer_skip;
        @(posedge i_ref_clk) disable iff (i_rst)
        i_wr_en && !o_xfer_chk_active |-> o_wr_commit;
    endproperty
    a_xfer_skip: assert property (p_xfer_skip) // (R1)
        else $error("write refused with checking off");

    property p_xfer_flag;
        @(posedge i_ref_clk) disable iff (i_rst)
        xfer_bad |=> o_err_flags.xfer_chk;
    endproperty
    a_xfer_flag: assert property (p_xfer_flag) // (R12)
        else $error("checksum flag not set");

    property p_map_flag;
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_err_flags.map_crc) |-> $past(cmp_fail);
    endproperty
    a_map_flag: assert property (p_map_flag) // (R2)
        else $error("map flag set without mismatch");

    property p_map_sticky;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_err_flags.map_crc && !i_err_clr.map_crc |=> o_err_flags.map_crc;
    endproperty
    a_map_sticky: assert property (p_map_sticky) // (R13)
        else $error("map flag dropped without clear");

    property p_ro_skip;
        @(posedge i_ref_clk) disable iff (i_rst)
        state_r == cim_pkg::S_SCAN && is_ro(scan_addr_r) |-> !take;
    endproperty
    a_ro_skip: assert property (p_ro_skip) // (R3)
        else $error("read-only word entered crc");

    property p_period;
        @(posedge i_ref_clk) disable iff (i_rst)
        chk_tick |=> timer_r == 13'h0000 ##1 !chk_tick [*8];
    endproperty
    a_period: assert property (p_period) // (R4)
        else $error("check period not restarted");

    sequence s_refresh_ev;
        any_ev;
    endsequence
    sequence s_ref_scan;
        refresh_pend_r || (state_r == cim_pkg::S_SCAN && ref_mode_r);
    endsequence
    property p_refresh;
        @(posedge i_ref_clk) disable iff (i_rst)
        s_refresh_ev |=> s_ref_scan;
    endproperty
    a_refresh: assert property (p_refresh) // (R6)
        else $error("refresh cause lost");

    property p_rom_once;
        @(posedge i_ref_clk) disable iff (i_rst)
        rom_started_r |-> !o_rom_check_start;
    endproperty
    a_rom_once: assert property (p_rom_once) // (R7)
        else $error("rom check restarted");

    property p_rom_gate;
        @(posedge i_ref_clk) disable iff (i_rst)
        !err_en_r[`EN_ROM_BIT] && !o_err_flags.rom |=> !o_err_flags.rom;
    endproperty
    a_rom_gate: assert property (p_rom_gate) // (R8)
        else $error("rom failure reported while gated");

endmodule // config_integrity_monitor
`default_nettype wire

// ### cim_map.svh
// register addresses, field positions, reset values and timings
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH

// register addresses
`define ADDR_STATUS     8'h00
`define ADDR_DATA       8'h01
`define ADDR_ERR_EN     8'h07
`define ADDR_CLK_CNT    8'h08
`define MAP_FIRST       8'h00
`define MAP_LAST        8'h4f

// error-enable field positions
`define EN_ROM_BIT      0
`define EN_MAP_BIT      1
`define EN_XFER_BIT     2
`define EN_CNT_BIT      10

// reset values
`define ERR_EN_RESET    24'h000000
`define CLK_CNT_RESET   8'h00

// timing
`define CLK_PERIOD_NS   100
`define CHK_PERIOD_NS   426600
`define REF_HZ          10000000
`define MCLK_HZ         76800
`define MCLK_PER_COUNT  131

// map checksum polynomial and seed
`define CRC_POLY        8'h07
`define CRC_SEED        8'hff

`endif

// ### cim_pkg.sv
// shared types of the configuration integrity monitor
package cim_pkg;

    // error flags, one per reported check
    typedef struct packed {
        logic xfer_chk;
        logic map_crc;
        logic rom;
    } err_flags_t;

    // causes that force a new reference checksum
    typedef struct packed {
        logic host_wr;
        logic cal;
        logic mode_idle;
        logic cont_off;
    } refresh_ev_t;

    // scan sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_SCAN = 3'b010,
        S_DONE = 3'b100
    } scan_state_t;

endpackage

// ### map_crc_engine.sv
// crc-8 accumulator over 24-bit map words, one word per cycle
`timescale 1ns/1ps
`default_nettype none
`include "cim_map.svh"

module map_crc_engine
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // word stream
    input  wire logic        i_clear,
    input  wire logic        i_take,
    input  wire logic [23:0] i_word,
    // result
    output logic      [7:0]  o_crc
);

    // bitwise crc over one word, msb first
    function automatic logic [7:0] crc_word(input logic [7:0] c,
                                            input logic [23:0] w);
        logic [7:0] r;
        r = c;
        for (int i = 23; i >= 0; i--)
        begin
            if (r[7] ^ w[i])
                r = {r[6:0], 1'b0} ^ `CRC_POLY;
            else
                r = {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // accumulator; clear takes priority so a new scan starts clean
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_crc <= `CRC_SEED;
        else if (i_clear)
            o_crc <= `CRC_SEED;
        else if (i_take)
            o_crc <= crc_word(o_crc, i_word);
    end

    property p_crc_hold;
        @(posedge i_ref_clk) disable iff (i_rst)
        !i_take && !i_clear |=> $stable(o_crc);
    endproperty
    a_crc_hold: assert property (p_crc_hold) // (R3)
        else $error("crc changed without a word");

endmodule // map_crc_engine
`default_nettype wire

// ### clock_tick_counter.sv
// master-clock activity counter with its own clock divider
`timescale 1ns/1ps
`default_nettype none
`include "cim_map.svh"

module clock_tick_counter
(
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // control
    input  wire logic       i_enable,
    // count value
    output logic      [7:0] o_count
);

    localparam int unsigned MCLK_DIV = `REF_HZ / `MCLK_HZ;
    localparam logic [7:0] DIV_LAST = 8'(MCLK_DIV - 1);
    localparam logic [7:0] PER_LAST = 8'(`MCLK_PER_COUNT - 1);

    logic [7:0] div_r;
    logic [7:0] per_r;
    logic       mclk_en;
    logic       step;

    // nominal master clock as a one-cycle enable
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            div_r <= 8'h00;
        else if (div_r == DIV_LAST)
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end
    assign mclk_en = (div_r == DIV_LAST);

    // master-clock pulses per count step
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            per_r <= 8'h00;
        else if (i_enable && mclk_en)
            per_r <= (per_r == PER_LAST) ? 8'h00 : per_r + 8'h01;
    end
    assign step = i_enable && mclk_en && (per_r == PER_LAST); // (R10)

    // count wraps naturally from its maximum to zero
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_count <= `CLK_CNT_RESET; // (R9)
        else if (step)
            o_count <= o_count + 8'h01; // (R10)
    end

    property p_cnt_step;
        @(posedge i_ref_clk) disable iff (i_rst)
        step |=> o_count == $past(o_count) + 8'h01;
    endproperty
    a_cnt_step: assert property (p_cnt_step) // (R10)
        else $error("counter did not advance or wrap");

    property p_cnt_hold;
        @(posedge i_ref_clk) disable iff (i_rst)
        !i_enable |=> $stable(o_count);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) // (R9)
        else $error("counter moved while disabled");

endmodule // clock_tick_counter
`default_nettype wire

// ### map_store_model.sv
// map memory and rom check responder beside the integrity monitor
`timescale 1ns/1ps
`default_nettype none

module map_store_model
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // writes committed by the monitor
    input  wire logic        i_commit,
    input  wire logic [7:0]  i_addr,
    input  wire logic [23:0] i_wdata,
    // scan read port
    input  wire logic [7:0]  i_scan_addr,
    output logic      [23:0] o_scan_data,
    // corruption injected by the bench
    input  wire logic        i_poke,
    input  wire logic [7:0]  i_poke_addr,
    input  wire logic [23:0] i_poke_data,
    // rom check
    input  wire logic        i_rom_start,
    input  wire logic        i_rom_bad,
    output logic             o_rom_done,
    output logic             o_rom_fail
);
    // ****************************************
    // map storage
    // ****************************************
    logic [23:0] mem_r [0:79];
    logic [3:0]  rom_cnt_r;

    // outside the map the read port shows a moving pattern, not old data
    assign o_scan_data = (i_scan_addr < 8'h50) ? mem_r[i_scan_addr[6:0]]
                                               : {3{i_scan_addr}};

    // only committed writes and bench pokes change the map
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < 80; k++)
                mem_r[k] <= 24'h000000;
        end
        else if (i_poke && i_poke_addr < 8'h50)
            mem_r[i_poke_addr[6:0]] <= i_poke_data;
        else if (i_commit && i_addr < 8'h50)
            mem_r[i_addr[6:0]] <= i_wdata;
    end

    // rom check answers some cycles after the power-up start pulse
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rom_cnt_r <= 4'h0;
        else if (i_rom_start)
            rom_cnt_r <= 4'h1;
        else if (rom_cnt_r != 4'h0)
            rom_cnt_r <= rom_cnt_r + 4'h1;
    end

    // the result line is meaningless outside the done pulse
    assign o_rom_done = (rom_cnt_r == 4'h6);
    assign o_rom_fail = o_rom_done ? i_rom_bad : ~i_rom_bad;
endmodule // map_store_model

`default_nettype wire

// ### config_integrity_monitor_tb.sv
// self-checking bench for the configuration integrity monitor
`timescale 1ns/1ps
`default_nettype none
`include "cim_map.svh"

module config_integrity_monitor_tb;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    localparam int unsigned CHK = 200;
    logic                i_ref_clk, i_rst, wr, ok, rd, cal, single, idle;
    logic                cont, poke, commit, rvalid, rom_start, rom_done;
    logic                rom_fail, xact;
    logic [7:0]          addr, paddr, scan_addr;
    logic [23:0]         wdata, pdata, scan_data, rdata, got;
    cim_pkg::err_flags_t clr, flags;
    int                  fail_count, check_count;

    config_integrity_monitor #(.CHK_CYCLES(CHK)) i_dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr_en(wr),
        .i_wr_chk_ok(ok), .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata),
        .o_wr_commit(commit), .o_rd_valid(rvalid), .o_rdata(rdata),
        .o_scan_addr(scan_addr), .i_scan_data(scan_data),
        .i_cal_done(cal), .i_mode_single(single), .i_mode_idle(idle),
        .i_continuous_read_bit(cont), .o_rom_check_start(rom_start),
        .i_rom_done(rom_done), .i_rom_fail(rom_fail), .i_err_clr(clr),
        .o_err_flags(flags), .o_xfer_chk_active(xact));

    map_store_model i_store (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_commit(commit),
        .i_addr(addr), .i_wdata(wdata), .i_scan_addr(scan_addr),
        .o_scan_data(scan_data), .i_poke(poke), .i_poke_addr(paddr),
        .i_poke_data(pdata), .i_rom_start(rom_start), .i_rom_bad(1'b1),
        .o_rom_done(rom_done), .o_rom_fail(rom_fail));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        check_count++;
        if (seen !== want)
        begin
            fail_count++;
            $display("BAD %0t saw %h wanted %h", $time, seen, want);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    // commit is combinational, so it is judged before the taking edge
    task automatic write(input logic [7:0] a, input logic [23:0] d,
                         input logic g, input logic exp);
        wr = 1'b1;
        addr = a;
        wdata = d;
        ok = g;
        #1;
        check({23'h0, commit}, {23'h0, exp});
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask

    task automatic read(input logic [7:0] a);
        rd = 1'b1;
        addr = a;
        cyc(1);
        rd = 1'b0;
        check({23'h0, rvalid}, 24'h1);
        got = rdata;
        cyc(1);
    endtask

    task automatic poke_map(input logic [7:0] a, input logic [23:0] d);
        poke = 1'b1;
        paddr = a;
        pdata = d;
        cyc(1);
        poke = 1'b0;
        cyc(1);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        read(`ADDR_CLK_CNT);
        check(got, 24'h000000);
        read(`ADDR_ERR_EN);
        check(got, `ERR_EN_RESET);
        cyc(10);
        check({23'h0, flags.rom}, 24'h0);
        write(`ADDR_ERR_EN, 24'h000001, 1'b1, 1'b1);
        cyc(2);
        check({23'h0, flags.rom}, 24'h1);
    endtask

    task automatic t_xfer;
        write(8'h20, 24'h000011, 1'b0, 1'b1);
        check({23'h0, flags.xfer_chk}, 24'h0);
        write(`ADDR_ERR_EN, 24'h000005, 1'b1, 1'b1);
        check({23'h0, xact}, 24'h1);
        write(8'h20, 24'h000022, 1'b0, 1'b0);
        check({23'h0, flags.xfer_chk}, 24'h1);
        clr.xfer_chk = 1'b1;
        cyc(1);
        clr.xfer_chk = 1'b0;
        cyc(1);
        check({23'h0, flags.xfer_chk}, 24'h0);
    endtask

    logic [7:0] paddr_list [3] = '{8'h00, 8'h01, 8'h08};

    // a changed word is ignored while disabled, caught while enabled
    task automatic t_map;
        poke_map(8'h30, 24'h00abcd);
        cyc(3 * CHK);
        check({23'h0, flags.map_crc}, 24'h0);
        poke_map(8'h30, 24'h000011);
        write(`ADDR_ERR_EN, 24'h000007, 1'b1, 1'b1);
        cyc(3 * CHK);
        check({23'h0, flags.map_crc}, 24'h0);
        poke_map(8'h30, 24'h00abcd);
        cyc(CHK + 100);
        check({23'h0, flags.map_crc}, 24'h1);
        cyc(2 * CHK);
        check({23'h0, flags.map_crc}, 24'h1);
        poke_map(8'h30, 24'h000011);
        cyc(CHK); // a stale compare must finish before the clear
        clr.map_crc = 1'b1;
        cyc(1);
        clr.map_crc = 1'b0;
        cyc(3 * CHK);
        check({23'h0, flags.map_crc}, 24'h0);
        foreach (paddr_list[k])
            poke_map(paddr_list[k], 24'h5a5a5a);
        cyc(3 * CHK);
        check({23'h0, flags.map_crc}, 24'h0);
    endtask

    // each refresh cause lands together with a change of the map
    task automatic t_refresh;
        single = 1'b1;
        cont = 1'b1;
        cyc(2);
        for (int e = 0; e < 4; e++)
        begin
            cal = (e == 1);
            single = (e < 2);
            idle = (e == 2);
            cont = (e != 3);
            if (e == 0)
                write(8'h21, 24'h000123, 1'b1, 1'b1);
            else
                poke_map(8'h21, 24'h000200 + 24'(e));
            cal = 1'b0;
            cyc(3 * CHK);
            check({23'h0, flags.map_crc}, 24'h0);
        end
    endtask

    // the host enables counting before it trusts the value
    task automatic t_count;
        write(`ADDR_ERR_EN, 24'h000407, 1'b1, 1'b1);
        cyc(130 * 131 + 100);
        read(`ADDR_CLK_CNT);
        check(got, 24'h000001);
        write(`ADDR_ERR_EN, 24'h000007, 1'b1, 1'b1);
        cyc(20000);
        read(`ADDR_CLK_CNT);
        check(got, 24'h000001);
    endtask

    task automatic results;
        if (fail_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // clock, watchdog and sequence
    // ****************************************
    initial
    begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // whole run needs about 43000 cycles
    initial
    begin
        #(100 * 70000);
        fail_count++;
        results();
    end

    initial
    begin
        {wr, ok, rd, cal, single, idle, cont, poke} = 8'h00;
        {addr, paddr, wdata, pdata} = 64'h0;
        clr = '0;
        fail_count = 0;
        check_count = 0;
        i_rst = 1'b1;
        cyc(4);
        check({23'h0, rom_start}, 24'h1);
        i_rst = 1'b0;
        cyc(1);
        t_reset();
        t_xfer();
        t_map();
        t_refresh();
        t_count();
        results();
    end
endmodule // config_integrity_monitor_tb

`default_nettype wire
